/* hdl/pcm_top.sv */
/*
 Pixel colour matrix stage: APB registers, native and luma chroma
 matrices, vividness adjust and an output FIFO.
 Assumes one pixel clock, first/last pixel flags on the stream and a
 gamma curve applied outside, not between the two matrix stages.
*/
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Output FIFO
// ****************************************
module pcm_fifo
	import pcm_pkg::*;
#(
	parameter int WIDTH = 26,
	parameter int DEPTH = 8
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
	} pcm_fifo_t;
	pcm_fifo_t st;
	pcm_fifo_t next_st;
	logic push;
	logic pop;

	// Honest flags from the count
	assign inReady = st.count != (AW+1)'(DEPTH);
	assign outValid = st.count != '0;
	assign outData = st.mem[st.rdPtr];
	assign level = st.count;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Pointer and count update
	always_comb
	begin
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wrPtr] = inData;
			next_st.wrPtr = st.wrPtr + 1'b1;
		end
		if (pop)
			next_st.rdPtr = st.rdPtr + 1'b1;
		next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

// ****************************************
// Colour matrix stage
// ****************************************
module pcm_top
	import pcm_pkg::*;
#(
	parameter int PW = 8,
	parameter int FIFO_DEPTH = 8,
	parameter bit POLARIZED = 1'b0,
	parameter pcm_coef_t [6:0][11:0] PRESET_COEFS = {7{PCM_IDENTITY_SET}},
	parameter pcm_coef_t [6:0] PRESET_RED = {7{PCM_COEF_ONE}},
	parameter pcm_coef_t [6:0] PRESET_BLUE = {7{PCM_COEF_ONE}},
	parameter pcm_coef_t [11:0] LUMA_COEFS = PCM_IDENTITY_SET
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PCM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pixels in
	input wire logic pixInValid,
	output logic pixInReady,
	input wire logic pixInSof,
	input wire logic pixInEof,
	input wire logic [PW-1:0] pixInRed,
	input wire logic [PW-1:0] pixInGreen,
	input wire logic [PW-1:0] pixInBlue,
	// Pixels out
	output logic pixOutValid,
	input wire logic pixOutReady,
	output logic pixOutSof,
	output logic pixOutEof,
	output logic [PW-1:0] pixOutC0,
	output logic [PW-1:0] pixOutC1,
	output logic [PW-1:0] pixOutC2
);
	localparam int SW = PCM_COEF_W + PW + 4;
	localparam int FW = 3 * PW + 2;
	localparam logic signed [SW-1:0] PIX_MAX =
		$signed({{(SW-PW){1'b0}}, {PW{1'b1}}});
	localparam bit PRESENT = !POLARIZED;

	typedef logic [2:0][PW-1:0] pcm_pix_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic pipeOn;
		pcm_instance_t pick;
		logic rgbOn;
		logic vividOn;
		logic lumaFmt;
		pcm_illum_t preset;
		pcm_coef_pick_t coefPick;
		pcm_coef_t vivid;
		pcm_coef_t redRatio;
		pcm_coef_t blueRatio;
		pcm_coef_t [1:0][11:0] coefs;
		pcm_coef_t [1:0][11:0] actCoefs;
		logic actPipe;
		logic actRgb;
		logic actVivid;
		logic actLuma;
		pcm_coef_t actVividV;
		logic inFrame;
		logic inReady;
		logic s1Valid;
		logic [1:0] s1Flags;
		pcm_pix_t s1Pix;
		logic s2Valid;
		logic [1:0] s2Flags;
		pcm_pix_t s2Pix;
		logic s3Valid;
		logic [1:0] s3Flags;
		pcm_pix_t s3Pix;
		logic outValid;
		logic [1:0] outFlags;
		pcm_pix_t outPix;
	} pcm_state_t;

	localparam pcm_state_t RESET_STATE = '{
		coefs: {LUMA_COEFS, PRESET_COEFS[0]},
		actCoefs: {LUMA_COEFS, PRESET_COEFS[0]},
		vivid: PCM_COEF_ONE, actVividV: PCM_COEF_ONE,
		redRatio: PRESET_RED[0], blueRatio: PRESET_BLUE[0],
		pick: NATIVE_TO_STANDARD_RGB, preset: ILLUM_GENERAL,
		coefPick: MATRIX_R0C0,
		default: '0};

	pcm_state_t st;
	pcm_state_t next_st;
	pcm_pix_t rgbRow;
	pcm_pix_t vividPix;
	pcm_pix_t lumaRow;
	pcm_pix_t matPix;
	logic eff;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [FW-1:0] fifoOutData;
	logic [$clog2(FIFO_DEPTH):0] fifoLevel;

	// ****************************************
	// Arithmetic helpers
	// ****************************************
	// Round off the fraction and clamp to the pixel range
	function automatic logic [PW-1:0] clampPix(input logic signed [SW-1:0] a);
		logic signed [SW-1:0] r;
		r = (a + (SW'(1) <<< (PCM_FRAC - 1))) >>> PCM_FRAC;
		if (r < 0)
			return '0;
		else if (r > PIX_MAX)
			return {PW{1'b1}};
		return r[PW-1:0];
	endfunction

	// One matrix row times the pixel plus that row's offset
	function automatic logic [PW-1:0] dotRow(input pcm_coef_t [2:0] g,
		input pcm_coef_t off, input pcm_pix_t p);
		logic signed [SW-1:0] acc;
		acc = SW'(off);
		for (int i = 0; i < 3; i++)
			acc = acc + SW'(g[i]) * $signed({{(SW-PW){1'b0}}, p[i]});
		return clampPix(acc);
	endfunction

	// Scale a channel's distance from the grey level
	function automatic logic [PW-1:0] vividChan(input pcm_coef_t s,
		input pcm_pix_t p, input int ch);
		logic signed [SW-1:0] y;
		logic signed [SW-1:0] d;
		y = ($signed(SW'(p[0])) + $signed(SW'(p[1])) * 2 +
			$signed(SW'(p[2]))) >>> 2;
		d = $signed(SW'(p[ch])) - y;
		return clampPix((y <<< PCM_FRAC) + SW'(s) * d);
	endfunction

	// Floating point word to fixed point, saturating
	function automatic pcm_coef_t floatToFixed(input logic [31:0] f);
		logic [47:0] m;
		logic [47:0] mag;
		int sh;
		m = {24'h0, 1'b1, f[22:0]};
		sh = int'(f[30:23]) - PCM_FLOAT_BIAS + PCM_FRAC - PCM_MANT_W;
		if (f[30:23] == 8'h00 || sh < -24)
			mag = '0;
		else if (sh > 24)
			mag = '1;
		else if (sh >= 0)
			mag = m << sh;
		else
			mag = (m + (48'h1 << (-sh - 1))) >> (-sh);
		if (mag > 48'(2 ** (PCM_COEF_W - 1) - 1))
			mag = 48'(2 ** (PCM_COEF_W - 1) - 1);
		return f[31] ? -pcm_coef_t'(mag[PCM_COEF_W-1:0]) :
			pcm_coef_t'(mag[PCM_COEF_W-1:0]);
	endfunction

	// Fixed point to floating point word, exact
	function automatic logic [31:0] fixedToFloat(input pcm_coef_t c);
		logic [PCM_COEF_W-1:0] a;
		logic [46:0] w;
		int p;
		a = c[PCM_COEF_W-1] ? -c : c;
		p = -1;
		for (int i = 0; i < PCM_COEF_W; i++)
			if (a[i])
				p = i;
		if (p < 0)
			return 32'h0000_0000;
		w = {27'h0, a} << (PCM_MANT_W - p);
		return {c[PCM_COEF_W-1], 8'(p - PCM_FRAC + PCM_FLOAT_BIAS),
			w[22:0]};
	endfunction

	// ****************************************
	// Per-channel datapath
	// ****************************************
	assign eff = st.actPipe && PRESENT;
	for (genvar ch = 0; ch < 3; ch++)
	begin : g_chan
		assign rgbRow[ch] = dotRow(st.actCoefs[0][3*ch +: 3],
			st.actCoefs[0][9+ch], st.s1Pix);
		assign matPix[ch] = (eff && st.actRgb) ? rgbRow[ch] :
			st.s1Pix[ch];
		assign vividPix[ch] = vividChan(st.actVividV, matPix, ch);
		assign lumaRow[ch] = dotRow(st.actCoefs[1][3*ch +: 3],
			st.actCoefs[1][9+ch], st.s2Pix);
	end

	// ****************************************
	// Registers, stream and pipeline
	// ****************************************
	always_comb
	begin
		logic acc;
		logic wrEdge;
		logic bad;
		logic [PCM_ADDR_W-1:0] a;
		acc = pixInValid && st.inReady;
		wrEdge = psel && penable && pwrite && st.pready && !st.pslverr;
		a = paddr;
		bad = 1'b0;
		next_st = st;
		next_st.pready = 1'b0;
		// Setup cycle: decide error and read data
		if (a != PCM_ADDR_CTRL && a != PCM_ADDR_STATUS &&
			!(st.pipeOn && PRESENT))
			bad = 1'b1;
		if (pwrite && a == PCM_ADDR_COEF_PICK &&
			pwdata[3:0] >= PCM_COEF_COUNT)
			bad = 1'b1;
		if (pwrite && a == PCM_ADDR_COEF_VALUE &&
			st.pick == NATIVE_TO_STANDARD_RGB && st.preset != ILLUM_CUSTOM)
			bad = 1'b1;
		if (psel && !penable)
		begin
			next_st.pready = 1'b1;
			next_st.prdata = '0;
			case (a)
				PCM_ADDR_CTRL:
				begin
					next_st.prdata[PCM_CTRL_PIPE_ON] = st.pipeOn;
					next_st.prdata[PCM_CTRL_PICK] = st.pick;
					next_st.prdata[PCM_CTRL_APPLY] =
						(st.pick == RGB_TO_LUMA_CHROMA) ? st.lumaFmt :
						st.rgbOn;
					next_st.prdata[PCM_CTRL_VIVID] = st.vividOn;
					next_st.prdata[PCM_CTRL_LUMA_FMT] = st.lumaFmt;
				end
				PCM_ADDR_PRESET: next_st.prdata[2:0] = st.preset;
				PCM_ADDR_COEF_PICK: next_st.prdata[3:0] = st.coefPick;
				PCM_ADDR_COEF_VALUE:
					next_st.prdata = fixedToFloat(
						st.actCoefs[st.pick][st.coefPick]);
				PCM_ADDR_VIVIDNESS:
					next_st.prdata[PCM_COEF_W-1:0] = st.vivid;
				PCM_ADDR_RED_RATIO:
					next_st.prdata[PCM_COEF_W-1:0] = st.redRatio;
				PCM_ADDR_BLUE_RATIO:
					next_st.prdata[PCM_COEF_W-1:0] = st.blueRatio;
				PCM_ADDR_STATUS:
				begin
					next_st.prdata[PCM_STAT_PRESENT] = PRESENT;
					next_st.prdata[PCM_STAT_RGB_ACTIVE] = eff && st.actRgb;
					next_st.prdata[PCM_STAT_LUMA_ACTIVE] = eff && st.actLuma;
					next_st.prdata[PCM_STAT_IN_FRAME] = st.inFrame;
				end
				default: bad = 1'b1;
			endcase
			if (bad)
				next_st.prdata = '0;
			next_st.pslverr = bad;
		end
		// Access edge: the write takes effect
		if (wrEdge)
		begin
			case (a)
				PCM_ADDR_CTRL:
				begin
					next_st.pipeOn = pwdata[PCM_CTRL_PIPE_ON];
					if (st.pipeOn && PRESENT)
					begin
						next_st.pick = pcm_instance_t'(pwdata[PCM_CTRL_PICK]);
						next_st.vividOn = pwdata[PCM_CTRL_VIVID];
						next_st.lumaFmt = pwdata[PCM_CTRL_LUMA_FMT];
						if (!pwdata[PCM_CTRL_PICK])
							next_st.rgbOn = pwdata[PCM_CTRL_APPLY];
					end
				end
				PCM_ADDR_PRESET:
				begin
					next_st.preset = pcm_illum_t'(pwdata[2:0]);
					if (pwdata[2:0] != ILLUM_CUSTOM)
					begin
						next_st.coefs[0] = PRESET_COEFS[pwdata[2:0]];
						next_st.redRatio = PRESET_RED[pwdata[2:0]];
						next_st.blueRatio = PRESET_BLUE[pwdata[2:0]];
					end
				end
				PCM_ADDR_COEF_PICK:
					next_st.coefPick = pcm_coef_pick_t'(pwdata[3:0]);
				PCM_ADDR_COEF_VALUE:
					next_st.coefs[st.pick][st.coefPick] =
						floatToFixed(pwdata);
				PCM_ADDR_VIVIDNESS: next_st.vivid = pwdata[PCM_COEF_W-1:0];
				PCM_ADDR_RED_RATIO: next_st.redRatio = pwdata[PCM_COEF_W-1:0];
				PCM_ADDR_BLUE_RATIO:
					next_st.blueRatio = pwdata[PCM_COEF_W-1:0];
				default: next_st.preset = st.preset;
			endcase
		end
		// Settings move to the datapath only between frames
		if (!st.inFrame)
		begin
			next_st.actCoefs = next_st.coefs;
			next_st.actPipe = next_st.pipeOn;
			next_st.actRgb = next_st.rgbOn;
			next_st.actVivid = next_st.vividOn;
			next_st.actLuma = next_st.lumaFmt;
			next_st.actVividV = next_st.vivid;
		end
		if (acc && pixInSof)
			next_st.inFrame = 1'b1;
		if (acc && pixInEof)
			next_st.inFrame = 1'b0;
		// Stage 1: input capture
		next_st.s1Valid = acc;
		next_st.s1Flags = {pixInSof, pixInEof};
		next_st.s1Pix = {pixInBlue, pixInGreen, pixInRed};
		// Stage 2: native matrix then vividness
		next_st.s2Valid = st.s1Valid;
		next_st.s2Flags = st.s1Flags;
		next_st.s2Pix = (eff && st.actVivid) ? vividPix : matPix;
		// Stage 3: luma chroma matrix, straight on the stage 2 output, no gamma between
		next_st.s3Valid = st.s2Valid;
		next_st.s3Flags = st.s2Flags;
		next_st.s3Pix = (eff && st.actLuma) ? lumaRow : st.s2Pix;
		// Intake stops while the FIFO lacks room for pixels in flight
		next_st.inReady = fifoInReady &&
			(fifoLevel <= ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - PCM_FIFO_MARGIN));
		// Output register drained by the downstream stage
		if (fifoOutReady)
		begin
			next_st.outValid = fifoOutValid;
			next_st.outFlags = fifoOutData[FW-1 -: 2];
			next_st.outPix = fifoOutData[3*PW-1:0];
		end
	end

	assign fifoOutReady = !st.outValid || pixOutReady;

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			st <= RESET_STATE;
		else
			st <= next_st;
	end

	// Output FIFO in the pixel path
	pcm_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.inValid(st.s3Valid),
		.inReady(fifoInReady),
		.inData({st.s3Flags, st.s3Pix}),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData),
		.level(fifoLevel)
	);

	// Ports from flip-flops
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign pixInReady = st.inReady;
	assign pixOutValid = st.outValid;
	assign pixOutSof = st.outFlags[1];
	assign pixOutEof = st.outFlags[0];
	assign pixOutC0 = st.outPix[0];
	assign pixOutC1 = st.outPix[1];
	assign pixOutC2 = st.outPix[2];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_setup;
		psel && !penable && !pready;
	endsequence
	sequence s_write_edge;
		psel && penable && pready && pwrite && !pslverr;
	endsequence
	// Any write access edge, refused or not
	sequence s_access;
		psel && penable && pready && pwrite;
	endsequence
	sequence s_through;
		st.s2Valid ##1 st.s3Valid;
	endsequence

	property p_dot_row;
		st.s1Valid && eff && st.actRgb && !st.actVivid |=>
			st.s2Pix == $past(rgbRow);
	endproperty
	a_dot_row: assert property (p_dot_row) else $error("row sum wrong");

	property p_gated_off;
		s_setup ##0 (paddr != PCM_ADDR_CTRL && paddr != PCM_ADDR_STATUS &&
			!st.pipeOn) |=> pready && pslverr && prdata == 32'h0000_0000;
	endproperty
	a_gated_off: assert property (p_gated_off) else $error("not refused");

	property p_absent_pass;
		st.s1Valid && !eff |=> st.s2Pix == $past(st.s1Pix);
	endproperty
	a_absent_pass: assert property (p_absent_pass) else $error("not bypassed");

	property p_bypass;
		st.s1Valid && eff && !st.actRgb && !st.actVivid |=>
			st.s2Pix == $past(st.s1Pix);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass broken");

	property p_custom_only;
		s_access ##0 (paddr == PCM_ADDR_COEF_VALUE &&
			st.pick == NATIVE_TO_STANDARD_RGB && st.preset != ILLUM_CUSTOM)
			|=> $stable(st.coefs);
	endproperty
	a_custom_only: assert property (p_custom_only)
		else $error("wrote preset");

	property p_order;
		st.s1Valid |=> s_through;
	endproperty
	a_order: assert property (p_order) else $error("stage order");

	property p_luma_pass;
		st.s2Valid && !(eff && st.actLuma) |=> st.s3Pix == $past(st.s2Pix);
	endproperty
	a_luma_pass: assert property (p_luma_pass) else $error("luma applied");

	property p_luma_ro;
		s_write_edge ##0 (paddr == PCM_ADDR_CTRL && pwdata[PCM_CTRL_PICK])
			|=> $stable(st.rgbOn);
	endproperty
	a_luma_ro: assert property (p_luma_ro) else $error("enable changed");

	property p_pick_range;
		s_setup ##0 (pwrite && paddr == PCM_ADDR_COEF_PICK &&
			pwdata[3:0] >= PCM_COEF_COUNT) |=> pslverr;
	endproperty
	a_pick_range: assert property (p_pick_range) else $error("bad pick");

	property p_ratio_load;
		s_write_edge ##0 (paddr == PCM_ADDR_PRESET &&
			pwdata[2:0] != ILLUM_CUSTOM) |=>
			st.redRatio == PRESET_RED[$past(pwdata[2:0])];
	endproperty
	a_ratio_load: assert property (p_ratio_load) else $error("no ratio");

	property p_frame_hold;
		st.inFrame |=> $stable(st.actCoefs) && $stable(st.actRgb);
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("mid frame");

	property p_fifo_room;
		st.s3Valid |-> fifoInReady;
	endproperty
	a_fifo_room: assert property (p_fifo_room) else $error("fifo overrun");
endmodule

`default_nettype wire

/* hdl/pcm_pkg.sv */
/*
 Constants and types of the pixel colour matrix stage.
 Assumes an APB register bus with 32-bit data and byte addresses.
*/
// Notes on behaviour
// - Each output is row dot input plus offset.
// - Controls work only while image pipeline on.
// - Polarised variants carry no transformation stage.
// - Instance pick steers enable and coefficient access.
// - Native matrix: 0 bypasses, 1 applies it.
// - Illuminant preset loads a calibrated matrix set.
// - Custom preset first, then write coefficients.
// - Luma chroma matrix follows native matrix, gamma; here it takes the stage 2 output directly, with no gamma.
// - Luma chroma conversion follows pixel format alone.
// - Enable is read-only for luma chroma instance.
// - Coefficient readback shows the value in use.
// - Twelve terms: nine gains, three offsets.
// - Coefficient value is a floating point word.
// - Preset also loads red and blue ratios.
// - Vividness on: saturation adjust; off: none.
package pcm_pkg;

	// ****************************************
	// Coefficient format
	// ****************************************
	localparam int PCM_COEF_W = 20;
	localparam int PCM_FRAC = 10;
	localparam int PCM_FLOAT_BIAS = 127;
	localparam int PCM_MANT_W = 23;
	typedef logic signed [PCM_COEF_W-1:0] pcm_coef_t;
	localparam pcm_coef_t PCM_COEF_ZERO = '0;
	localparam pcm_coef_t PCM_COEF_ONE = pcm_coef_t'(1 << PCM_FRAC);
	localparam pcm_coef_t [11:0] PCM_IDENTITY_SET = {PCM_COEF_ZERO,
		PCM_COEF_ZERO, PCM_COEF_ZERO, PCM_COEF_ONE, PCM_COEF_ZERO,
		PCM_COEF_ZERO, PCM_COEF_ZERO, PCM_COEF_ONE, PCM_COEF_ZERO,
		PCM_COEF_ZERO, PCM_COEF_ZERO, PCM_COEF_ONE};

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam int PCM_ADDR_W = 8;
	localparam logic [7:0] PCM_ADDR_CTRL = 8'h00;
	localparam logic [7:0] PCM_ADDR_PRESET = 8'h04;
	localparam logic [7:0] PCM_ADDR_COEF_PICK = 8'h08;
	localparam logic [7:0] PCM_ADDR_COEF_VALUE = 8'h0C;
	localparam logic [7:0] PCM_ADDR_VIVIDNESS = 8'h10;
	localparam logic [7:0] PCM_ADDR_RED_RATIO = 8'h14;
	localparam logic [7:0] PCM_ADDR_BLUE_RATIO = 8'h18;
	localparam logic [7:0] PCM_ADDR_STATUS = 8'h1C;
	localparam int PCM_CTRL_PIPE_ON = 0;
	localparam int PCM_CTRL_PICK = 1;
	localparam int PCM_CTRL_APPLY = 2;
	localparam int PCM_CTRL_VIVID = 3;
	localparam int PCM_CTRL_LUMA_FMT = 4;
	localparam int PCM_STAT_PRESENT = 0;
	localparam int PCM_STAT_RGB_ACTIVE = 1;
	localparam int PCM_STAT_LUMA_ACTIVE = 2;
	localparam int PCM_STAT_IN_FRAME = 3;
	localparam logic [3:0] PCM_COEF_COUNT = 4'hC;
	localparam int PCM_FIFO_MARGIN = 5;

	// ****************************************
	// Enumerations
	// ****************************************
	typedef enum logic {NATIVE_TO_STANDARD_RGB, RGB_TO_LUMA_CHROMA}
		pcm_instance_t;
	typedef enum logic [2:0] {ILLUM_GENERAL, ILLUM_TUNGSTEN,
		ILLUM_WARM_FLUOR, ILLUM_COOL_FLUOR, ILLUM_DAYLIGHT, ILLUM_CLOUDY,
		ILLUM_SHADE, ILLUM_CUSTOM} pcm_illum_t;
	typedef enum logic [3:0] {MATRIX_R0C0, MATRIX_R0C1, MATRIX_R0C2,
		MATRIX_R1C0, MATRIX_R1C1, MATRIX_R1C2, MATRIX_R2C0, MATRIX_R2C1,
		MATRIX_R2C2, CHANNEL_BIAS_FIRST, CHANNEL_BIAS_SECOND,
		CHANNEL_BIAS_THIRD} pcm_coef_pick_t;

endpackage

/* bench/pcm_sink.sv */
/*
 Downstream stage model: takes pixels from the colour matrix stage.
 Assumes the stage's pixel clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Downstream sink
// ****************************************
module pcm_sink
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Stall mode: 0 always ready, 1 random stalls, 2 stopped
	input wire logic [1:0] stallMode,
	// Handshake
	output logic pixOutReady
);
	// Ready moves only just after an edge, like a real stage
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			pixOutReady <= 1'b0;
		else if (stallMode == 2'h1)
			pixOutReady <= 1'($urandom);
		else
			pixOutReady <= (stallMode == 2'h0);
	end
endmodule
`default_nettype wire

/* bench/pcm_top_tb_top.sv */
/*
 Self-checking bench of the colour matrix stage: APB, pixels, FIFO.
 Assumes default parameters: identity presets, luma matrix, ratios.
*/
`timescale 1ns/10ps
`default_nettype none

module pcm_top_tb_top
	import pcm_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, pixInValid = 0, pixInReady, pixInSof = 0;
	logic pixInEof = 0, pixOutValid, pixOutReady, pixOutSof, pixOutEof;
	logic [7:0] pixInRed = 0, pixInGreen = 0, pixInBlue = 0;
	logic [7:0] pixOutC0, pixOutC1, pixOutC2;
	logic [1:0] stallMode = 2'h0;
	logic [25:0] q[$];
	int errorCnt = 0, checked = 0;

	pcm_top i_pcm_top (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pixInValid(pixInValid),
		.pixInReady(pixInReady), .pixInSof(pixInSof),
		.pixInEof(pixInEof), .pixInRed(pixInRed),
		.pixInGreen(pixInGreen), .pixInBlue(pixInBlue),
		.pixOutValid(pixOutValid), .pixOutReady(pixOutReady),
		.pixOutSof(pixOutSof), .pixOutEof(pixOutEof),
		.pixOutC0(pixOutC0), .pixOutC1(pixOutC1), .pixOutC2(pixOutC2));
	pcm_sink i_pcm_sink (.ref_clk(ref_clk), .resetn(resetn),
		.stallMode(stallMode), .pixOutReady(pixOutReady));

	// Clock of 10 ns
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	// ****************************************
	// Checking tasks
	// ****************************************
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic hang();
		errorCnt++;
		final_report();
	endtask

	// One APB transfer; waits for pready, checks error and read data
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic eErr, input logic [31:0] eRd);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			hang();
		chk(32'(pslverr), 32'(eErr));
		if (!wr && !eErr)
			chk(prdata, eRd);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Expected pixel: 0 identity, 1 doubled red plus one, 2 grey
	function automatic logic [23:0] want(logic [7:0] r, logic [7:0] g,
		logic [7:0] b, int m);
		logic [9:0] y;
		y = (10'(r) + 10'(g) * 2 + 10'(b)) >> 2;
		if (m == 1)
			return {(r > 8'h7F) ? 8'hFF : 8'(r * 2 + 1), g, b};
		if (m == 2)
			return {y[7:0], y[7:0], y[7:0]};
		return {r, g, b};
	endfunction

	// Sends one frame of n pixels and waits until all came out
	task automatic frame(input int n, input int m, input string s);
		int k;
		for (int i = 0; i < n; i++)
		begin
			pixInValid <= 1'b1;
			pixInSof <= (i == 0);
			pixInEof <= (i == n - 1);
			pixInRed <= 8'($urandom);
			pixInGreen <= 8'($urandom);
			pixInBlue <= 8'($urandom);
			k = 0;
			do
			begin
				@(posedge ref_clk);
				k++;
			end
			while (pixInReady !== 1'b1 && k < 200);
			if (k >= 200)
				hang();
			q.push_back({i == 0, i == n - 1,
				want(pixInRed, pixInGreen, pixInBlue, m)});
		end
		pixInValid <= 1'b0;
		for (k = 0; k < 300 && q.size() > 0; k++)
			@(posedge ref_clk);
		if (q.size() > 0)
			hang();
		$display("Test %s done", s);
	endtask

	// Output watcher: oldest note against each pixel taken
	always @(posedge ref_clk)
	begin
		if (resetn && pixOutValid === 1'b1 && pixOutReady === 1'b1)
		begin
			if (q.size() == 0)
				chk(32'h1, 32'h0);
			else
				chk(32'({pixOutSof, pixOutEof, pixOutC0, pixOutC1,
					pixOutC2}), 32'(q.pop_front()));
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		void'($urandom(40324));
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		apb(0, PCM_ADDR_CTRL, 0, 0, 32'h0);
		apb(0, PCM_ADDR_STATUS, 0, 0, 32'h1);
		apb(0, PCM_ADDR_PRESET, 0, 1, 0);
		frame(4, 0, "pipe off");
		apb(1, PCM_ADDR_CTRL, 32'h1, 0, 0);
		apb(0, 8'h20, 0, 1, 0);
		apb(1, PCM_ADDR_COEF_PICK, 32'hC, 1, 0);
		apb(1, PCM_ADDR_COEF_VALUE, 32'h40000000, 1, 0);
		frame(6, 0, "bypass");
		apb(1, PCM_ADDR_PRESET, 32'h7, 0, 0);
		apb(1, PCM_ADDR_COEF_PICK, 32'h0, 0, 0);
		apb(1, PCM_ADDR_COEF_VALUE, 32'h40000000, 0, 0);
		apb(1, PCM_ADDR_COEF_PICK, 32'h9, 0, 0);
		apb(1, PCM_ADDR_COEF_VALUE, 32'h3F800000, 0, 0);
		apb(0, PCM_ADDR_COEF_VALUE, 0, 0, 32'h3F800000);
		apb(1, PCM_ADDR_CTRL, 32'h5, 0, 0);
		apb(0, PCM_ADDR_STATUS, 0, 0, 32'h3);
		stallMode <= 2'h1;
		frame(12, 1, "custom");
		apb(1, PCM_ADDR_RED_RATIO, 32'h200, 0, 0);
		apb(1, PCM_ADDR_PRESET, 32'h3, 0, 0);
		apb(0, PCM_ADDR_RED_RATIO, 0, 0, 32'h400);
		apb(0, PCM_ADDR_COEF_VALUE, 0, 0, 32'h0);
		apb(1, PCM_ADDR_CTRL, 32'h7, 0, 0);
		apb(0, PCM_ADDR_CTRL, 0, 0, 32'h3);
		apb(1, PCM_ADDR_COEF_PICK, 32'h4, 0, 0);
		apb(1, PCM_ADDR_COEF_VALUE, 32'h40000000, 0, 0);
		apb(0, PCM_ADDR_COEF_VALUE, 0, 0, 32'h40000000);
		apb(1, PCM_ADDR_CTRL, 32'h13, 0, 0);
		apb(0, PCM_ADDR_STATUS, 0, 0, 32'h7);
		apb(0, PCM_ADDR_CTRL, 0, 0, 32'h17);
		apb(1, PCM_ADDR_CTRL, 32'h9, 0, 0);
		apb(0, PCM_ADDR_COEF_VALUE, 0, 0, 32'h3F800000);
		apb(1, PCM_ADDR_VIVIDNESS, 32'h0, 0, 0);
		stallMode <= 2'h2;
		fork
			frame(10, 2, "vivid");
			begin
				repeat (40) @(posedge ref_clk);
				chk(32'(pixInReady), 32'h0);
				stallMode <= 2'h1;
			end
		join
		final_report();
	end
endmodule
`default_nettype wire
